// ---- design/cbc_pkg.sv ----
package cbc_pkg;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Vector locations, low byte then high byte
  localparam logic [15:0] VEC_NMI_LO = 16'hFFFA;
  localparam logic [15:0] VEC_NMI_HI = 16'hFFFB;
  localparam logic [15:0] VEC_RST_LO = 16'hFFFC;
  localparam logic [15:0] VEC_RST_HI = 16'hFFFD;
  localparam logic [15:0] VEC_IRQ_LO = 16'hFFFE;
  localparam logic [15:0] VEC_IRQ_HI = 16'hFFFF;

  // Stack page and status bit positions
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam int IFLAG_BIT = 2;
  localparam int VFLAG_BIT = 6;

  // Processor cycles of initialisation after reset release
  localparam logic [2:0] INIT_CYCLES = 3'h6;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_RST_HOLD = 8'h01,
    ST_RST_INIT = 8'h02,
    ST_RUN = 8'h04,
    ST_PUSH_H = 8'h08,
    ST_PUSH_L = 8'h10,
    ST_PUSH_P = 8'h20,
    ST_VEC_LO = 8'h40,
    ST_VEC_HI = 8'h80
  } cbc_state_t;

  // Bus cycle requested by the core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic opfetch;
    logic last;
  } cbc_req_t;

  // Core context saved by an interrupt
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] sp;
    logic [7:0] status;
  } cbc_ctx_t;

  // External bus pins
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rw_n;
    logic data_oe_n;
    logic sync;
  } cbc_bus_t;

  // Whole state of the control block
  typedef struct packed {
    cbc_state_t st;
    logic phase;
    cbc_req_t cyc;
    cbc_bus_t bus;
    logic [7:0] rd_data;
    logic rd_valid;
    logic take;
    logic halted;
    logic [2:0] init_cnt;
    logic res_prev;
    logic nmi_prev;
    logic nmi_pend;
    logic so_prev;
    logic iflag;
    logic vflag;
    logic vec_nmi;
    logic vec_rst;
    logic [7:0] vec_lo;
    logic [15:0] pc_save;
    logic [7:0] sp;
    logic [7:0] psave;
    logic pc_load;
    logic [15:0] pc_value;
  } cbc_regs_t;

endpackage

// ---- design/cbc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Data drivers enabled only for the clock after an edge that saw drive-enable high.
// - Read cycles keep data drivers off whatever drive-enable says.
// - Ready low in phase one of a non-write cycle halts, address held.
// - Ready low in a write cycle is ignored until the next read.
// - Maskable request served after the instruction only if mask clear.
// - Interrupt pushes PC and status, then sets the mask flag.
// - Maskable vector is FFFE low, FFFF high.
// - No interrupt is recognised while ready is low.
// - Falling NMI edge runs the same sequence, ignoring the mask.
// - Non-maskable vector is FFFA low, FFFB high.
// - Interrupts sampled in phase two, sequence starts on next phase one.
// - Falling set-overflow edge, sampled end of phase one, sets overflow.
// - Opcode-fetch marker high for the whole of each opcode fetch cycle.
// - Ready low in the marker cycle freezes the processor until high.
// - No write transfers while the reset input is low.
// - Reset sequence starts at once on reset input rising edge.
// - After six cycles set mask flag, load PC from FFFC and FFFD.
// - Data bus is eight bits wide and bidirectional.
module cbc_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reset_input_n,
  input wire logic ready,
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire logic set_overflow_n,
  input wire logic data_drive_enable,
  input wire logic [cbc_pkg::DATA_W-1:0] data_in,
  input wire cbc_pkg::cbc_req_t core_req,
  input wire cbc_pkg::cbc_ctx_t core_ctx,
  input wire logic core_iflag_wr,
  input wire logic core_iflag_val,
  input wire logic core_vflag_wr,
  input wire logic core_vflag_val,
  output cbc_pkg::cbc_bus_t bus,
  output logic [cbc_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic core_take,
  output logic core_halted,
  output logic phase_two,
  output logic pc_load,
  output logic [cbc_pkg::ADDR_W-1:0] pc_value,
  output logic [7:0] sp_value,
  output logic iflag,
  output logic vflag
);
  import cbc_pkg::*;

  cbc_regs_t r_ff;
  cbc_regs_t nxt_r;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic nmi_edge;
  logic so_edge;
  logic int_go;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Next-state logic
  always_comb begin
    nxt_r = r_ff;
    nxt_r.take = 1'b0;
    nxt_r.rd_valid = 1'b0;
    nxt_r.pc_load = 1'b0;
    nxt_r.res_prev = reset_input_n;
    nmi_edge = 1'b0;
    so_edge = 1'b0;
    int_go = 1'b0;

    // Set-overflow sampled at the end of phase one
    if (!r_ff.phase) begin
      nxt_r.so_prev = set_overflow_n;
      so_edge = r_ff.so_prev && !set_overflow_n;
    end
    // Interrupt inputs sampled at the end of phase two
    if (r_ff.phase) begin
      nxt_r.nmi_prev = nmi_n;
      nmi_edge = r_ff.nmi_prev && !nmi_n;
    end

    // Core flag writes; hardware set wins over core clear
    if (core_vflag_wr) begin
      nxt_r.vflag = core_vflag_val;
    end
    if (so_edge) begin
      nxt_r.vflag = 1'b1;
    end
    if (core_iflag_wr) begin
      nxt_r.iflag = core_iflag_val;
    end

    if (!r_ff.phase) begin
      // End of phase one: halt on ready low unless writing
      if (!ready && r_ff.bus.rw_n) begin
        nxt_r.halted = 1'b1;
      end else begin
        nxt_r.halted = 1'b0;
        nxt_r.phase = 1'b1;
      end
    end else begin
      // End of phase two: cycle completes
      nxt_r.phase = 1'b0;
      if (r_ff.bus.rw_n) begin
        nxt_r.rd_data = data_in;
        nxt_r.rd_valid = (r_ff.st == ST_RUN);
      end
      case (r_ff.st)
        ST_RST_HOLD: begin
          nxt_r.st = ST_RST_HOLD;
        end
        ST_RST_INIT: begin
          nxt_r.sp = 8'(r_ff.sp - 8'h01);
          if (r_ff.init_cnt == 3'(INIT_CYCLES - 3'h1)) begin
            nxt_r.iflag = 1'b1;
            nxt_r.vec_rst = 1'b1;
            nxt_r.vec_nmi = 1'b0;
            nxt_r.st = ST_VEC_LO;
          end else begin
            nxt_r.init_cnt = 3'(r_ff.init_cnt + 3'h1);
          end
        end
        ST_RUN: begin
          // Decide on interrupt entry at instruction end
          int_go = r_ff.cyc.last && ready &&
            (r_ff.nmi_pend || nmi_edge ||
            (!irq_n && !r_ff.iflag));
          if (int_go) begin
            nxt_r.vec_nmi = r_ff.nmi_pend || nmi_edge;
            nxt_r.vec_rst = 1'b0;
            nxt_r.pc_save = core_ctx.pc;
            nxt_r.sp = core_ctx.sp;
            nxt_r.psave = core_ctx.status;
            nxt_r.psave[IFLAG_BIT] = r_ff.iflag;
            nxt_r.psave[VFLAG_BIT] = r_ff.vflag;
            nxt_r.st = ST_PUSH_H;
          end else begin
            nxt_r.cyc = core_req;
            nxt_r.take = 1'b1;
          end
        end
        ST_PUSH_H: begin
          nxt_r.sp = 8'(r_ff.sp - 8'h01);
          nxt_r.st = ST_PUSH_L;
        end
        ST_PUSH_L: begin
          nxt_r.sp = 8'(r_ff.sp - 8'h01);
          nxt_r.st = ST_PUSH_P;
        end
        ST_PUSH_P: begin
          nxt_r.sp = 8'(r_ff.sp - 8'h01);
          nxt_r.iflag = 1'b1;
          nxt_r.st = ST_VEC_LO;
        end
        ST_VEC_LO: begin
          nxt_r.vec_lo = data_in;
          nxt_r.st = ST_VEC_HI;
        end
        ST_VEC_HI: begin
          nxt_r.pc_load = 1'b1;
          nxt_r.pc_value = {data_in, r_ff.vec_lo};
          nxt_r.vec_rst = 1'b0;
          nxt_r.cyc = core_req;
          nxt_r.take = 1'b1;
          nxt_r.st = ST_RUN;
        end
        default: begin
          nxt_r.st = ST_RST_HOLD;
        end
      endcase
    end

    // NMI edge latch; a new edge wins over the clear
    if (int_go && nxt_r.vec_nmi) begin
      nxt_r.nmi_pend = 1'b0;
    end
    if (nmi_edge && !(int_go && !r_ff.nmi_pend)) begin
      nxt_r.nmi_pend = 1'b1;
    end

    // Reset input overrides sequencer state, phase, halt and take
    if (!reset_input_n) begin
      nxt_r.st = ST_RST_HOLD;
      nxt_r.phase = 1'b0;
      nxt_r.halted = 1'b0;
      nxt_r.take = 1'b0;
    end else if (!r_ff.res_prev) begin
      nxt_r.st = ST_RST_INIT;
      nxt_r.init_cnt = 3'h0;
      nxt_r.phase = 1'b0;
      nxt_r.halted = 1'b0;
      nxt_r.sp = core_ctx.sp;
    end

    // Drive the bus for the cycle in progress
    nxt_r.bus.sync = 1'b0;
    nxt_r.bus.rw_n = 1'b1;
    nxt_r.bus.wdata = 8'h00;
    nxt_r.bus.addr = {STACK_PAGE, nxt_r.sp};
    case (nxt_r.st)
      ST_RUN: begin
        nxt_r.bus.addr = nxt_r.cyc.addr;
        nxt_r.bus.rw_n = !nxt_r.cyc.write;
        nxt_r.bus.wdata = nxt_r.cyc.wdata;
        nxt_r.bus.sync = nxt_r.cyc.opfetch;
      end
      ST_PUSH_H: begin
        nxt_r.bus.rw_n = 1'b0;
        nxt_r.bus.wdata = nxt_r.pc_save[15:8];
      end
      ST_PUSH_L: begin
        nxt_r.bus.rw_n = 1'b0;
        nxt_r.bus.wdata = nxt_r.pc_save[7:0];
      end
      ST_PUSH_P: begin
        nxt_r.bus.rw_n = 1'b0;
        nxt_r.bus.wdata = nxt_r.psave;
      end
      ST_VEC_LO: begin
        nxt_r.bus.addr = nxt_r.vec_rst ? VEC_RST_LO :
          (nxt_r.vec_nmi ? VEC_NMI_LO : VEC_IRQ_LO);
      end
      ST_VEC_HI: begin
        nxt_r.bus.addr = nxt_r.vec_rst ? VEC_RST_HI :
          (nxt_r.vec_nmi ? VEC_NMI_HI : VEC_IRQ_HI);
      end
      default: begin
        nxt_r.bus.rw_n = 1'b1;
      end
    endcase
    // Drivers on only for writes with drive-enable high
    nxt_r.bus.data_oe_n = !(!nxt_r.bus.rw_n && data_drive_enable);
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      r_ff <= '{st: ST_RST_HOLD, bus: '{addr: 16'h0000, wdata: 8'h00,
        rw_n: 1'b1, data_oe_n: 1'b1, sync: 1'b0},
        res_prev: 1'b0, nmi_prev: 1'b1, so_prev: 1'b1, iflag: 1'b1,
        default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from the state register
  assign bus = r_ff.bus;
  assign rd_data = r_ff.rd_data;
  assign rd_valid = r_ff.rd_valid;
  assign core_take = r_ff.take;
  assign core_halted = r_ff.halted;
  assign phase_two = r_ff.phase;
  assign pc_load = r_ff.pc_load;
  assign pc_value = r_ff.pc_value;
  assign sp_value = r_ff.sp;
  assign iflag = r_ff.iflag;
  assign vflag = r_ff.vflag;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_ff);

  // Push and vector steps of an interrupt
  sequence seq_push;
    r_ff.st == ST_PUSH_H [*2] ##1 r_ff.st == ST_PUSH_L [*2]
      ##1 r_ff.st == ST_PUSH_P [*2];
  endsequence
  sequence seq_vec_entry;
    r_ff.iflag && r_ff.st == ST_VEC_LO;
  endsequence

  AST_OE_NEEDS_DBE: assert property (
    !bus.data_oe_n |-> $past(data_drive_enable) && !bus.rw_n)
    else $error("data drivers on without drive enable");
  AST_OE_OFF_READ: assert property (
    bus.rw_n |-> bus.data_oe_n)
    else $error("data drivers on during a read");
  AST_HALT_HOLDS_ADDR: assert property (
    r_ff.halted && $past(r_ff.halted) |-> $stable(bus.addr) && !phase_two)
    else $error("address moved while halted");
  AST_WRITE_NO_HALT: assert property (
    !r_ff.phase && !bus.rw_n && !ready && reset_input_n |=> r_ff.phase)
    else $error("write cycle halted by ready");
  AST_IRQ_MASKED: assert property (
    $rose(r_ff.st == ST_PUSH_H) && !r_ff.vec_nmi |-> !$past(r_ff.iflag))
    else $error("masked request entered interrupt");
  AST_PUSH_ORDER: assert property (
    disable iff (!rst_sync_ff || !reset_input_n)
    $rose(r_ff.st == ST_PUSH_H) |-> seq_push ##1 seq_vec_entry)
    else $error("push or mask order wrong");
  AST_IRQ_VECTOR: assert property (
    $rose(r_ff.st == ST_VEC_HI) && !r_ff.vec_nmi && !r_ff.vec_rst
    |-> bus.addr == VEC_IRQ_HI && $past(bus.addr, 2) == VEC_IRQ_LO)
    else $error("maskable vector address wrong");
  AST_NO_INT_HALTED: assert property (
    $rose(r_ff.st == ST_PUSH_H) |-> $past(ready) && !r_ff.phase)
    else $error("interrupt entered while not ready");
  AST_NMI_VECTOR: assert property (
    $rose(r_ff.st == ST_VEC_HI) && r_ff.vec_nmi && !r_ff.vec_rst
    |-> bus.addr == VEC_NMI_HI && $past(bus.addr, 2) == VEC_NMI_LO)
    else $error("non-maskable vector address wrong");
  AST_SO_SETS_V: assert property (
    !r_ff.phase && r_ff.so_prev && !set_overflow_n |=> r_ff.vflag)
    else $error("overflow flag not set");
  AST_SYNC_FETCH: assert property (
    bus.sync |-> bus.rw_n && r_ff.st == ST_RUN && r_ff.cyc.opfetch)
    else $error("fetch marker outside fetch cycle");
  AST_RESET_NO_WRITE: assert property (
    !$past(reset_input_n) |-> bus.rw_n && bus.data_oe_n)
    else $error("write while reset input low");
  AST_RESET_START: assert property (
    reset_input_n && !r_ff.res_prev
    |=> r_ff.st == ST_RST_INIT && r_ff.init_cnt == 3'h0)
    else $error("reset sequence did not start");
  AST_RESET_VECTOR: assert property (
    $rose(r_ff.st == ST_VEC_LO) && r_ff.vec_rst
    |-> r_ff.iflag && bus.addr == VEC_RST_LO)
    else $error("reset vector fetch wrong");
  AST_NMI_ONCE: assert property (
    $fell(r_ff.nmi_pend) |-> r_ff.st == ST_PUSH_H && r_ff.vec_nmi)
    else $error("pending NMI lost");

endmodule

`default_nettype wire

// ---- verification/cbc_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Memory and bus partner facing the control block
module cbc_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire cbc_pkg::cbc_bus_t bus,
  input wire logic phase_two,
  input wire logic steal,
  input wire logic clr,
  output logic [cbc_pkg::DATA_W-1:0] data_in,
  output logic data_drive_enable,
  output logic [2:0] wr_cnt,
  output logic [3:0][15:0] wr_addr,
  output logic [3:0][7:0] wr_data
);
  import cbc_pkg::*;

  // Byte pattern taken from the address
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction

  // Enable follows phase two unless another master owns the bus
  assign data_drive_enable = phase_two & ~steal;

  // Reads answered; otherwise an inverted value so stale data never matches
  assign data_in = bus.rw_n ? mem_byte(bus.addr) : ~mem_byte(bus.addr);

  // Log writes at the edge that ends their phase two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt <= 3'h0;
    end else if (clr) begin
      wr_cnt <= 3'h0;
    end else if (phase_two && !bus.rw_n && wr_cnt < 3'h4) begin
      wr_addr[wr_cnt[1:0]] <= bus.addr;
      wr_data[wr_cnt[1:0]] <= bus.wdata;
      wr_cnt <= wr_cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cbc_pkg::*;
  logic sys_clk, rst_n, reset_input_n, ready, irq_n, nmi_n, set_overflow_n;
  logic core_iflag_wr, core_iflag_val, core_vflag_wr, core_vflag_val;
  logic steal, clr, data_drive_enable, rd_valid, core_take, core_halted;
  logic phase_two, pc_load, iflag, vflag, dbe_q, oe_seen;
  logic [DATA_W-1:0] data_in, rd_data;
  logic [7:0] sp_value;
  logic [ADDR_W-1:0] pc_value, addr_q;
  logic [2:0] wr_cnt;
  logic [3:0][15:0] wr_addr;
  logic [3:0][7:0] wr_data;
  cbc_req_t core_req;
  cbc_ctx_t core_ctx;
  cbc_bus_t bus;
  int failures, n_tests;

  cbc_ctrl cbc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .reset_input_n(reset_input_n), .ready(ready), .irq_n(irq_n),
    .nmi_n(nmi_n), .set_overflow_n(set_overflow_n),
    .data_drive_enable(data_drive_enable), .data_in(data_in),
    .core_req(core_req), .core_ctx(core_ctx),
    .core_iflag_wr(core_iflag_wr), .core_iflag_val(core_iflag_val),
    .core_vflag_wr(core_vflag_wr), .core_vflag_val(core_vflag_val),
    .bus(bus), .rd_data(rd_data), .rd_valid(rd_valid),
    .core_take(core_take), .core_halted(core_halted),
    .phase_two(phase_two), .pc_load(pc_load), .pc_value(pc_value),
    .sp_value(sp_value), .iflag(iflag), .vflag(vflag));

  cbc_mem_model cbc_mem_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus), .phase_two(phase_two), .steal(steal), .clr(clr),
    .data_in(data_in), .data_drive_enable(data_drive_enable),
    .wr_cnt(wr_cnt), .wr_addr(wr_addr), .wr_data(wr_data));

  // 40 MHz clock; the block splits it into two phases
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Step to just after the next rising edge
  task automatic drv();
    @(posedge sys_clk);
    #2;
  endtask

  task automatic wait_pc(output int n);
    n = 0;
    do begin
      drv();
      n++;
    end while (pc_load !== 1'b1 && n < 80);
  endtask

  task automatic set_mask(input logic v);
    core_iflag_wr = 1'b1;
    core_iflag_val = v;
    drv();
    core_iflag_wr = 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Core stand-in: fresh request one edge after each take
  always @(posedge sys_clk) begin
    if (core_take === 1'b1) begin
      #2;
      core_req.addr = core_req.addr + 16'h0001;
      core_req.opfetch = ~core_req.opfetch;
    end
  end

  // Enable and address as seen by the block at each edge
  always @(posedge sys_clk) begin
    dbe_q <= data_drive_enable;
    addr_q <= bus.addr;
  end

  // Bus watch: request echo, fetch marker, driver enable
  always @(negedge sys_clk) begin
    if (core_take === 1'b1) begin
      chk({bus.addr, bus.rw_n}, {core_req.addr, 1'b1});
      chk(bus.sync, core_req.opfetch);
    end
    if (rd_valid === 1'b1) chk(rd_data, mb(addr_q));
    if (bus.data_oe_n === 1'b0) begin
      oe_seen = 1'b1;
      if (bus.rw_n !== 1'b0 || dbe_q !== 1'b1) chk(1, 0);
    end
  end

  task automatic t_reset();
    int n;
    repeat (6) drv();
    chk(wr_cnt, 0);
    reset_input_n = 1'b1;
    wait_pc(n);
    chk(n, 2 * INIT_CYCLES + 5);
    chk({pc_value, iflag}, {mb(VEC_RST_HI), mb(VEC_RST_LO), 1'b1});
    $display("test reset done");
  endtask

  task automatic t_step();
    logic [15:0] a;
    int k;
    k = 0;
    do begin
      drv();
      k++;
    end while (!(bus.sync === 1'b1 && core_take === 1'b1) && k < 40);
    a = bus.addr;
    ready = 1'b0;
    repeat (8) begin
      drv();
      chk({bus.addr, core_take, phase_two}, {a, 2'b00});
    end
    chk(core_halted, 1);
    ready = 1'b1;
    k = 0;
    do begin
      drv();
      k++;
    end while (core_take !== 1'b1 && k < 8);
    chk(k < 8, 1);
    chk({rd_valid, core_halted, rd_data}, {1'b1, 1'b0, mb(a)});
    $display("test single step done");
  endtask

  task automatic t_irq();
    int n;
    clr = 1'b1;
    oe_seen = 1'b0;
    drv();
    clr = 1'b0;
    irq_n = 1'b0;
    repeat (20) drv();
    chk(wr_cnt, 0);
    set_mask(1'b0);
    n = 0;
    while (bus.rw_n !== 1'b0 && n < 40) begin
      drv();
      n++;
    end
    chk(n < 40, 1);
    irq_n = 1'b1;
    ready = 1'b0;
    repeat (8) drv();
    chk({wr_cnt, core_halted}, {3'h3, 1'b1});
    ready = 1'b1;
    wait_pc(n);
    chk(pc_value, {mb(VEC_IRQ_HI), mb(VEC_IRQ_LO)});
    chk({wr_addr[0], wr_data[0], wr_data[1], wr_data[2]},
        {STACK_PAGE, 8'hFD, 8'h12, 8'h34, 8'h81});
    chk({wr_addr[1], wr_addr[2]},
        {STACK_PAGE, 8'hFC, STACK_PAGE, 8'hFB});
    chk({sp_value, iflag, oe_seen}, {8'hFA, 1'b1, 1'b1});
    $display("test maskable done");
  endtask

  task automatic t_rdy();
    int n;
    clr = 1'b1;
    drv();
    clr = 1'b0;
    set_mask(1'b0);
    irq_n = 1'b0;
    // Ready high at phase-one ends, low at every instruction end
    repeat (20) begin
      ready = ~phase_two;
      drv();
    end
    ready = 1'b1;
    chk(wr_cnt, 0);
    n = 0;
    while (bus.rw_n !== 1'b0 && n < 40) begin
      drv();
      n++;
    end
    irq_n = 1'b1;
    wait_pc(n);
    chk(pc_value, {mb(VEC_IRQ_HI), mb(VEC_IRQ_LO)});
    $display("test ready gate done");
  endtask

  task automatic t_nmi();
    int n;
    clr = 1'b1;
    oe_seen = 1'b0;
    steal = 1'b1;
    core_req.last = 1'b0;
    repeat (3) drv();
    clr = 1'b0;
    nmi_n = 1'b0;
    repeat (6) drv();
    chk(wr_cnt, 0);
    core_req.last = 1'b1;
    wait_pc(n);
    chk(pc_value, {mb(VEC_NMI_HI), mb(VEC_NMI_LO)});
    chk({wr_cnt, oe_seen, wr_data[2]}, {3'h3, 1'b0, 8'h85});
    n = 0;
    repeat (40) begin
      drv();
      if (pc_load === 1'b1) n++;
    end
    chk(n, 0);
    nmi_n = 1'b1;
    steal = 1'b0;
    $display("test non-maskable done");
  endtask

  task automatic t_so();
    set_overflow_n = 1'b0;
    repeat (4) drv();
    chk(vflag, 1);
    core_vflag_wr = 1'b1;
    core_vflag_val = 1'b0;
    drv();
    core_vflag_wr = 1'b0;
    repeat (4) drv();
    chk(vflag, 0);
    set_overflow_n = 1'b1;
    $display("test overflow done");
  endtask

  task automatic t_hold();
    int n;
    clr = 1'b1;
    drv();
    clr = 1'b0;
    set_mask(1'b0);
    irq_n = 1'b0;
    n = 0;
    while (bus.rw_n !== 1'b0 && n < 40) begin
      drv();
      n++;
    end
    reset_input_n = 1'b0;
    irq_n = 1'b1;
    repeat (6) drv();
    chk({wr_cnt, bus.rw_n, bus.data_oe_n, iflag},
        {3'h0, 1'b1, 1'b1, 1'b0});
    reset_input_n = 1'b1;
    wait_pc(n);
    chk(n, 2 * INIT_CYCLES + 5);
    chk({pc_value, iflag}, {mb(VEC_RST_HI), mb(VEC_RST_LO), 1'b1});
    $display("test reset in flight done");
  endtask

  // Watchdog
  initial begin
    #500000;
    failures++;
    complete_run();
  end

  // Main sequence; reset pin held low well past two cycles
  initial begin
    failures = 0;
    n_tests = 0;
    rst_n = 1'b0;
    reset_input_n = 1'b0;
    {ready, irq_n, nmi_n, set_overflow_n} = 4'hF;
    {core_iflag_wr, core_iflag_val, core_vflag_wr, core_vflag_val} = 4'h0;
    {steal, clr, oe_seen} = 3'h0;
    core_req = '0;
    core_req.addr = 16'h0200;
    core_req.opfetch = 1'b1;
    core_req.last = 1'b1;
    core_ctx = {16'h1234, 8'hFD, 8'h81};
    repeat (16) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    t_reset();
    t_step();
    t_irq();
    t_rdy();
    t_nmi();
    t_so();
    t_hold();
    complete_run();
  end
endmodule
`default_nettype wire
